// [rtl/ifeb_bank.sv]
/*
 Interrupt flag and enable bank: two sparse flag registers, four enable registers,
 per-source pending outputs, reached over an Avalon-MM slave with waitrequest.
 Assumes peripheral event inputs are synchronous to clk_sys and one cycle wide or level.
 Assumes the bus master holds each request until it sees waitrequest low, and
 that the enables of the two flag sources are gated by logic outside this bank.
 Registers sit in the low half of each bus word; upper byte lanes are ignored.
*/
// The placing of the registers and the Avalon-MM interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`include "ifeb_consts.svh"

// Overview of operation
// - Self-tune event sets flag six bit ten
// - Test controller event sets flag seven bit five
// - Unimplemented bits always read zero
// - Software reads and writes implemented bits
// - Flag one means request pending
// - Enable one passes request, zero blocks
// - Enable zero maps fifteen sources, bit fifteen unused
// - Enable one bits seven to five unused
// - Enable two bits fifteen, twelve, eleven unused
// - Enable three maps its listed sources
module ifeb_bank
   import ifeb_pkg::*;
(
   // Clock and reset
   input  wire logic        clk_sys,
   input  wire logic        sys_rst,
   // Avalon-MM slave
   input  wire ifeb_req_t   avmReq,
   output logic [31:0]      avmReadData,
   output logic             avmWaitRequest,
   // Peripheral events
   input  wire logic        selfTuneEvent,
   input  wire logic        testCtrlEvent,
   // Pending requests to priority logic, enable copies to gating elsewhere
   output logic [1:0]       flagPending,
   output logic [15:0]      enableOut0,
   output logic [15:0]      enableOut1,
   output logic [15:0]      enableOut2,
   output logic [15:0]      enableOut3
);

   // Register state; only the implemented bits can ever hold a one,
   // because every write passes through the implemented-bit mask.
   // Storage is plain flip-flops, one word a register.
   logic [15:0] irqFlags6_r;   // Self-tune flag register
   logic [15:0] irqFlags7_r;   // Test controller flag register
   logic [15:0] irqEnable0_r;  // Enable register zero
   logic [15:0] irqEnable1_r;  // Enable register one
   logic [15:0] irqEnable2_r;  // Enable register two
   logic [15:0] irqEnable3_r;  // Enable register three
   logic [31:0] readData_r;    // Registered read answer
   logic        waitReq_r;     // Registered waitrequest
   logic [1:0]  pending_r;     // Registered pending
   ifeb_phase_t phase_r;       // Bus phase
   logic [3:0]  regIdx;        // Word index
   logic        busWr;         // Write takes effect
   logic [15:0] wrData;        // Write data, low half
   logic        wrLow;         // Low byte lane enabled
   logic        wrHigh;        // High byte lane enabled

   // Merge written bytes under the implemented mask
   // Lanes not enabled keep their old value, so software can update
   // one byte of a register without a read-modify-write cycle.
   // The mask is applied last, which keeps unused bits at zero.
   function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] mask);
      logic [15:0] v;
      v = old;
      if (wrLow) begin
         v[7:0] = wrData[7:0];
      end
      if (wrHigh) begin
         v[15:8] = wrData[15:8];
      end
      merge = v & mask;
   endfunction

   // Decode the bus request
   // Word index from the byte address; the two low address bits are
   // ignored, so a misaligned address hits the word that contains it.
   always_comb begin
      regIdx = avmReq.address[5:2];
      wrData = avmReq.writedata[15:0];
      wrLow  = avmReq.byteenable[0];
      wrHigh = avmReq.byteenable[1];
      // Write commits only at the edge where waitrequest is low
      busWr  = avmReq.write && !waitReq_r;
   end

   // Handshake: one wait cycle, then answer; keeps reads registered
   // The wait cycle costs bus bandwidth but lets the read mux sit behind a
   // flop, so the read path never reaches straight from address to data.
   // Waitrequest idles high so no request is taken by surprise.
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         // Idle, holding the master off
         phase_r   <= IFEB_IDLE;
         waitReq_r <= 1'b1;
      end else begin
         case (phase_r)
            IFEB_IDLE: begin
               // A new request: answer at the next edge
               if (avmReq.read || avmReq.write) begin
                  phase_r   <= IFEB_DONE;
                  waitReq_r <= 1'b0;
               end
            end
            IFEB_DONE: begin
               // Answer given; back to waiting
               phase_r   <= IFEB_IDLE;
               waitReq_r <= 1'b1;
            end
            default: begin
               // Illegal code recovers to idle
               phase_r   <= IFEB_IDLE;
               waitReq_r <= 1'b1;
            end
         endcase
      end
   end

   // Read mux; unmapped words answer zero
   // Captured on every cycle that read stands, so the value the master
   // takes at the answering edge was sampled one edge earlier.
   // Data stand until the next read, which is harmless to the master.
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         readData_r <= `IFEB_UNMAPPED;
      end else if (avmReq.read) begin
         case (regIdx)
            `IFEB_OFS_FLAGS6: readData_r <= {16'h0000, irqFlags6_r};
            `IFEB_OFS_FLAGS7: readData_r <= {16'h0000, irqFlags7_r};
            `IFEB_OFS_EN0:    readData_r <= {16'h0000, irqEnable0_r};
            `IFEB_OFS_EN1:    readData_r <= {16'h0000, irqEnable1_r};
            `IFEB_OFS_EN2:    readData_r <= {16'h0000, irqEnable2_r};
            `IFEB_OFS_EN3:    readData_r <= {16'h0000, irqEnable3_r};
            default:          readData_r <= `IFEB_UNMAPPED;
         endcase
      end
   end

   // Flag six: event set wins over a software clear in the same cycle
   // A clear that loses is simply repeated by software; a lost event
   // could never be recovered, hence this priority.
   // The later assignment overrides the write within the same edge.
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         irqFlags6_r <= `IFEB_RST_VAL;
      end else begin
         if (busWr && regIdx == `IFEB_OFS_FLAGS6) begin
            irqFlags6_r <= merge(irqFlags6_r, `IFEB_MASK_FLAGS6);
         end
         if (selfTuneEvent) begin
            irqFlags6_r[`IFEB_POS_SELFTUNE] <= 1'b1;
         end
      end
   end

   // Flag seven: same set-over-clear priority
   // Only bit five is real; the mask keeps all others at zero.
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         irqFlags7_r <= `IFEB_RST_VAL;
      end else begin
         if (busWr && regIdx == `IFEB_OFS_FLAGS7) begin
            irqFlags7_r <= merge(irqFlags7_r, `IFEB_MASK_FLAGS7);
         end
         if (testCtrlEvent) begin
            irqFlags7_r[`IFEB_BIT_TESTCTRL] <= 1'b1;
         end
      end
   end

   // Enable registers; masks fix unused bits at zero
   // Enables change only by software; no hardware path ever sets them.
   // All four share one process since they share one write strobe.
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         irqEnable0_r <= `IFEB_RST_VAL;
         irqEnable1_r <= `IFEB_RST_VAL;
         irqEnable2_r <= `IFEB_RST_VAL;
         irqEnable3_r <= `IFEB_RST_VAL;
      end else if (busWr) begin
         case (regIdx)
            `IFEB_OFS_EN0: irqEnable0_r <= merge(irqEnable0_r, `IFEB_MASK_EN0);
            `IFEB_OFS_EN1: irqEnable1_r <= merge(irqEnable1_r, `IFEB_MASK_EN1);
            `IFEB_OFS_EN2: irqEnable2_r <= merge(irqEnable2_r, `IFEB_MASK_EN2);
            `IFEB_OFS_EN3: irqEnable3_r <= merge(irqEnable3_r, `IFEB_MASK_EN3);
            default: begin
               // Other words leave enables alone
            end
         endcase
      end
   end

   // Pending: the raw flag, one cycle behind it. The enable bits that gate
   // these two sources live in enable registers outside this bank, so the
   // AND with the enable is formed where those registers sit.
   // Registering the pending bits keeps every output straight from a flop,
   // at the cost of one cycle of latency towards the priority logic.
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         // Nothing pending out of reset
         pending_r <= 2'b00;
      end else begin
         // Self-tune request
         pending_r[0] <= irqFlags6_r[`IFEB_POS_SELFTUNE];
         // Test controller request
         pending_r[1] <= irqFlags7_r[`IFEB_BIT_TESTCTRL];
      end
   end

   // Outputs straight from flip-flops
   // Enable copies feed the gating of the peripheral sources elsewhere;
   // a zero enable bit there blocks its request
   assign avmReadData    = readData_r;
   assign avmWaitRequest = waitReq_r;
   assign flagPending    = pending_r;
   assign enableOut0     = irqEnable0_r;
   assign enableOut1     = irqEnable1_r;
   assign enableOut2     = irqEnable2_r;
   assign enableOut3     = irqEnable3_r;

   // Assertions
   // Each guards one rule on what the bank itself drives; those that look
   // back with $past are disabled in reset so they start clean after it.

   // Unused bits of flag six and enable zero stay zero
   a_reserved_zero_read: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (irqEnable0_r & ~`IFEB_MASK_EN0) == 16'h0000 && (irqFlags6_r & ~`IFEB_MASK_FLAGS6) == 16'h0000)
      else $error("Unimplemented bit set");

   // Unused bits of flag seven and enable one stay zero
   a_reserved_zero_mid: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (irqFlags7_r & ~`IFEB_MASK_FLAGS7) == 16'h0000 && (irqEnable1_r & ~`IFEB_MASK_EN1) == 16'h0000)
      else $error("Unimplemented flag seven or enable one bit set");

   // Unused bits of enables two and three stay zero
   a_reserved_zero_high: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (irqEnable2_r & ~`IFEB_MASK_EN2) == 16'h0000 && (irqEnable3_r & ~`IFEB_MASK_EN3) == 16'h0000)
      else $error("Unimplemented enable two or three bit set");

   // Events set their flags at the next edge
   a_selftune_set: assert property (@(posedge clk_sys) disable iff (sys_rst)
      selfTuneEvent |=> irqFlags6_r[`IFEB_POS_SELFTUNE])
      else $error("Self-tune flag not set");

   a_testctrl_set: assert property (@(posedge clk_sys) disable iff (sys_rst)
      testCtrlEvent |=> irqFlags7_r[`IFEB_BIT_TESTCTRL])
      else $error("Test controller flag not set");

   // A set self-tune flag stays pending until software writes its register
   a_flag_holds: assert property (@(posedge clk_sys) disable iff (sys_rst)
      irqFlags6_r[`IFEB_POS_SELFTUNE] && !(busWr && regIdx == `IFEB_OFS_FLAGS6)
      |=> irqFlags6_r[`IFEB_POS_SELFTUNE])
      else $error("Self-tune flag lost without a write");

   // Reset clears the bank and parks the bus
   a_reset_clears: assert property (@(posedge clk_sys)
      sys_rst |=> irqEnable3_r == 16'h0000 && irqFlags7_r == 16'h0000)
      else $error("Reset did not clear bank");

   a_reset_idle: assert property (@(posedge clk_sys)
      sys_rst |=> waitReq_r && readData_r == 32'h0000_0000 && pending_r == 2'b00)
      else $error("Reset did not park the bus");

   // Writes land only when answered
   a_write_en0: assert property (@(posedge clk_sys) disable iff (sys_rst)
      busWr && regIdx == `IFEB_OFS_EN0 && wrLow && wrHigh |=> irqEnable0_r == ($past(wrData) & `IFEB_MASK_EN0))
      else $error("Enable zero write lost");

   a_no_early_write: assert property (@(posedge clk_sys) disable iff (sys_rst)
      waitReq_r |=> $stable(irqEnable0_r) && $stable(irqEnable3_r))
      else $error("Enable changed while the bus waited");

   // Pending follows the flags one cycle later
   a_pending_flag: assert property (@(posedge clk_sys) disable iff (sys_rst)
      pending_r[1] |-> $past(irqFlags7_r[`IFEB_BIT_TESTCTRL]))
      else $error("Pending without flag");

   a_pending_self: assert property (@(posedge clk_sys) disable iff (sys_rst)
      pending_r[0] == $past(irqFlags6_r[`IFEB_POS_SELFTUNE]))
      else $error("Self-tune pending differs from its flag");

   // One wait cycle a request
   a_wait_one_cycle: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (avmReq.read || avmReq.write) && waitReq_r |=> !waitReq_r)
      else $error("Answer not within one cycle");

   // Gaps inside enables one and two stay zero
   a_en1_gap_zero: assert property (@(posedge clk_sys) disable iff (sys_rst)
      irqEnable1_r[7:5] == 3'b000 && irqEnable2_r[12:11] == 2'b00)
      else $error("Unused enable bits set");

endmodule

// [rtl/ifeb_consts.svh]
/*
 Register offsets, implemented-bit masks and bit positions of the interrupt flag and enable bank.
 Assumes it is included by its bare name in every file that needs it.
*/
`ifndef IFEB_CONSTS_SVH
`define IFEB_CONSTS_SVH

// Word indices on the register bus (byte address bits five to two)
`define IFEB_OFS_FLAGS6   4'h0
`define IFEB_OFS_FLAGS7   4'h1
`define IFEB_OFS_EN0      4'h2
`define IFEB_OFS_EN1      4'h3
`define IFEB_OFS_EN2      4'h4
`define IFEB_OFS_EN3      4'h5

// Implemented-bit masks; all other bits read zero
`define IFEB_MASK_FLAGS6  16'h0400
`define IFEB_MASK_FLAGS7  16'h0020
`define IFEB_MASK_EN0     16'h7FFF
`define IFEB_MASK_EN1     16'hFF1F
`define IFEB_MASK_EN2     16'h67FF
`define IFEB_MASK_EN3     16'h7DE6

// Bit positions of the two flags
`define IFEB_BIT_SELFTUNE 10
`define IFEB_BIT_TESTCTRL 5
`define IFEB_POS_SELFTUNE 10

// Reset value of every register
`define IFEB_RST_VAL      16'h0000

// Bus answer for an unmapped read
`define IFEB_UNMAPPED     32'h0000_0000

`endif

// [rtl/ifeb_pkg.sv]
/*
 Types shared by the interrupt flag and enable bank.
 Assumes the constants header is compiled alongside.
*/
package ifeb_pkg;

   // Register bus request from the Avalon-MM master
   typedef struct packed {
      logic [5:0]  address;    // Byte address
      logic        read;       // Read request
      logic        write;      // Write request
      logic [31:0] writedata;  // Write data
      logic [3:0]  byteenable; // Byte lanes
   } ifeb_req_t;

   // Bus access phase
   typedef enum logic [1:0] {
      IFEB_IDLE = 2'b01,
      IFEB_DONE = 2'b10
   } ifeb_phase_t;

endpackage

// [sim/ifeb_src_model.sv]
/*
 Model of the peripheral event sources that feed the flag bank.
 Assumes the bench asks for events just after a rising edge of clk_sys.
*/
`timescale 1ns/1ps
module ifeb_src_model (
   // Clock
   input  wire logic       clk_sys,
   // Bench commands, one bit a source
   input  wire logic [1:0] fireReq,
   // Event lines into the bank
   output logic            selfTuneEvent = 1'b0,
   output logic            testCtrlEvent = 1'b0
);
   // Events follow the command one cycle later, changed just after the edge
   // Only internal sources fire, so no external input needs a pin route
   always @(posedge clk_sys) begin
      selfTuneEvent <= fireReq[0];
      testCtrlEvent <= fireReq[1];
   end
endmodule

// [sim/tb.sv]
/*
 Self-checking bench for the interrupt flag and enable bank.
 Assumes one wait cycle a bus request and raw flags on flagPending.
*/
`timescale 1ns/1ps
module tb;
   import ifeb_pkg::*;
   logic        clk_sys;         // System clock
   logic        sys_rst;         // Synchronous reset
   ifeb_req_t   avmReq;          // Bus request
   logic [31:0] avmReadData;     // Read data
   logic        avmWaitRequest;  // Wait request
   logic [1:0]  fireReq;         // Event commands
   logic        selfTuneEvent;   // Self-tune event
   logic        testCtrlEvent;   // Test controller event
   logic [1:0]  flagPending;     // Raw flags
   logic [15:0] enOut [4];       // Enable copies
   logic [31:0] rd;              // Last read
   int          miscompares;     // Mismatches
   int          samples_checked; // Comparisons
   // Rows: address beside the read back expected after writing all ones
   localparam logic [5:0]  ADR [7] = '{6'h00, 6'h04, 6'h08, 6'h0C, 6'h10, 6'h14, 6'h18};
   localparam logic [15:0] MSK [7] = '{16'h0400, 16'h0020, 16'h7FFF, 16'hFF1F, 16'h67FF, 16'h7DE6, 16'h0000};

   ifeb_bank i_dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .avmReq(avmReq), .avmReadData(avmReadData),
      .avmWaitRequest(avmWaitRequest), .selfTuneEvent(selfTuneEvent), .testCtrlEvent(testCtrlEvent),
      .flagPending(flagPending), .enableOut0(enOut[0]), .enableOut1(enOut[1]), .enableOut2(enOut[2]),
      .enableOut3(enOut[3]));
   ifeb_src_model i_src (.clk_sys(clk_sys), .fireReq(fireReq), .selfTuneEvent(selfTuneEvent),
      .testCtrlEvent(testCtrlEvent));

   // Compare and count
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // One Avalon-MM transfer, held until waitrequest is seen low
   task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d, output logic [31:0] q);
      int n;
      n = 0;
      avmReq.address   <= a;
      avmReq.writedata <= d;
      avmReq.write     <= wr;
      avmReq.read      <= ~wr;
      do begin
         @(posedge clk_sys);
         n++;
      end while (avmWaitRequest !== 1'b0 && n < 50);
      q = avmReadData;
      if (n >= 50) miscompares++;
      avmReq.write <= 1'b0;
      avmReq.read  <= 1'b0;
      // Idle edge so the next request is a fresh assignment
      @(posedge clk_sys);
   endtask

   // Verdict and end of run
   task automatic end_sim();
      $display("checks %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   // Clock
   initial begin
      clk_sys = 1'b0;
      forever #10 clk_sys = ~clk_sys;
   end

   // Watchdog, far beyond the roughly 150 cycles the tests need
   initial begin
      #100000;
      miscompares++;
      end_sim();
   end

   // Main sequence
   initial begin
      sys_rst = 1'b1;
      avmReq = '0;
      avmReq.byteenable = 4'hF;
      fireReq = 2'b00;
      miscompares = 0;
      samples_checked = 0;
      repeat (3) @(posedge clk_sys);
      sys_rst <= 1'b0;
      @(posedge clk_sys);
      chk({31'h0, avmWaitRequest}, 32'h1);
      for (int i = 0; i < 7; i++) begin
         bus(1'b0, ADR[i], '0, rd);
         chk(rd, 32'h0);
      end
      chk({30'h0, flagPending}, 32'h0);
      $display("test reset done");
      // Row loop: all ones then zero into every place
      for (int i = 0; i < 7; i++) begin
         bus(1'b1, ADR[i], 32'hFFFF_FFFF, rd);
         bus(1'b0, ADR[i], '0, rd);
         chk(rd, {16'h0, MSK[i]});
         if (i > 1 && i < 6) chk({16'h0, enOut[i-2]}, {16'h0, MSK[i]});
         bus(1'b1, ADR[i], '0, rd);
         bus(1'b0, ADR[i], '0, rd);
         chk(rd, 32'h0);
      end
      $display("test rows done");
      // Both sources fire together, then software clears them
      fireReq <= 2'b11;
      @(posedge clk_sys);
      fireReq <= 2'b00;
      repeat (3) @(posedge clk_sys);
      chk({30'h0, flagPending}, 32'h3);
      bus(1'b0, 6'h00, '0, rd);
      chk(rd, 32'h0400);
      bus(1'b0, 6'h04, '0, rd);
      chk(rd, 32'h0020);
      bus(1'b1, 6'h00, '0, rd);
      bus(1'b1, 6'h04, '0, rd);
      repeat (2) @(posedge clk_sys);
      chk({30'h0, flagPending}, 32'h0);
      $display("test events done");
      // Event held across a software clear: the set wins
      fireReq <= 2'b01;
      @(posedge clk_sys);
      bus(1'b1, 6'h00, '0, rd);
      fireReq <= 2'b00;
      bus(1'b0, 6'h00, '0, rd);
      chk(rd, 32'h0400);
      bus(1'b1, 6'h00, '0, rd);
      bus(1'b0, 6'h00, '0, rd);
      chk(rd, 32'h0);
      // Low byte lane only
      avmReq.byteenable <= 4'h1;
      bus(1'b1, 6'h0C, 32'hFFFF_FFFF, rd);
      avmReq.byteenable <= 4'hF;
      bus(1'b0, 6'h0C, '0, rd);
      chk(rd, 32'h001F);
      $display("test awkward done");
      // Reset in mid-run wipes a set enable
      bus(1'b1, 6'h08, 32'h0000_7FFF, rd);
      chk({16'h0, enOut[0]}, 32'h7FFF);
      sys_rst <= 1'b1;
      repeat (2) @(posedge clk_sys);
      sys_rst <= 1'b0;
      @(posedge clk_sys);
      chk({16'h0, enOut[0]}, 32'h0);
      chk({31'h0, avmWaitRequest}, 32'h1);
      $display("test second reset done");
      end_sim();
   end
endmodule
